// *** dv/bridge_model.sv ***
// Bus bridge DMA controller model: issues whole-word beats to the data location.
// Assumes one shared clock and an ack pulse that closes each beat.
`timescale 1ns/1ns
`default_nettype none
module bridge_model (
  // Clock
  input  wire logic                       clk,
  // Data location
  output var  fifo_dma_pkg::bus_req_type  bus_req,
  input  wire fifo_dma_pkg::bus_resp_type bus_resp
);
  import fifo_dma_pkg::*;
  initial bus_req = '0;
  task automatic beat(input logic wr, input logic [BEAT_W-1:0] wd,
                      output logic [BEAT_W-1:0] rd, output logic ok);
    ok = 1'b0;
    rd = '0;
    @(posedge clk);
    // Request and data stand until ack is seen; the block leaves its ack cycle as a gap
    bus_req.write <= wr;
    bus_req.read  <= !wr;
    bus_req.wdata <= wd;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk);
      if (bus_resp.ack === 1'b1) begin
        rd = bus_resp.rdata;
        ok = 1'b1;
      end
    end
    bus_req.write <= 1'b0;
    bus_req.read  <= 1'b0;
    bus_req.wdata <= ~wd;
  endtask
endmodule // bridge_model
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for one channel's data location and demand handshake.
// Assumes the bridge model drives beats; the bench plays the serial side.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import fifo_dma_pkg::*;
  logic               core_clk, rst_n, tx_pop, tx_byte_valid, rx_push, ok;
  logic [BYTE_W-1:0]  tx_byte, rx_byte;
  logic [COUNT_W-1:0] tx_count, rx_count;
  logic [BEAT_W-1:0]  rd;
  bus_req_type        bus_req;
  bus_resp_type       bus_resp;
  dma_ctrl_type       dma_ctrl;
  dma_req_type        dma_req;
  int                 num_errors = 0;
  int                 n_checks = 0;

  fifo_dma_demand_handshake DUT (.core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req),
    .bus_resp(bus_resp), .dma_ctrl(dma_ctrl), .dma_req(dma_req), .tx_pop(tx_pop),
    .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid), .rx_push(rx_push),
    .rx_byte(rx_byte), .tx_count(tx_count), .rx_count(rx_count));
  bridge_model bridge (.clk(core_clk), .bus_req(bus_req), .bus_resp(bus_resp));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input logic [BEAT_W-1:0] seen, input logic [BEAT_W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic do_beat(input logic wr, input logic [BEAT_W-1:0] wd);
    bridge.beat(wr, wd, rd, ok);
    check(ok, 1'b1);
    if (ok !== 1'b1) test_done();
  endtask

  task automatic pop_tx(input logic [BYTE_W-1:0] exp);
    @(posedge core_clk);
    tx_pop <= 1'b1;
    @(posedge core_clk);
    tx_pop <= 1'b0;
    @(posedge core_clk);
    check(tx_byte_valid, 1'b1);
    check(tx_byte, exp);
  endtask

  task automatic push_rx(input logic [BYTE_W-1:0] b);
    @(posedge core_clk);
    rx_push <= 1'b1;
    rx_byte <= b;
    @(posedge core_clk);
    rx_push <= 1'b0;
    rx_byte <= ~b;
  endtask

  // Bounded wait for one request line to reach a level
  task automatic wait_req(input logic tx, input logic val);
    logic seen;
    seen = ~val;
    for (int i = 0; i < 4 && seen !== val; i++) begin
      @(posedge core_clk);
      seen = tx ? dma_req.tx_req : dma_req.rx_req;
    end
    check(seen, val);
    if (seen !== val) test_done();
  endtask

  task automatic t_tx_order();
    dma_ctrl <= '{1'b0, 1'b1, 1'b1};
    do_beat(1'b1, 32'h44332211);
    @(posedge core_clk);
    check(tx_count, 10'h004);
    for (int i = 0; i < 4; i++) pop_tx(8'(8'h11 * (i + 1)));
    check(tx_count, COUNT_ZERO);
    check(dma_req, 2'h0);
  endtask

  task automatic t_tx_full();
    for (int i = 0; i < 129; i++) do_beat(1'b1, {4{8'(i)}});
    @(posedge core_clk);
    check(tx_count, COUNT_FULL);
    dma_ctrl <= '{1'b1, 1'b1, 1'b0};
    repeat (3) @(posedge core_clk);
    check(dma_req.tx_req, 1'b0);
    pop_tx(8'h00);
    wait_req(1'b1, 1'b1);
    dma_ctrl <= '{1'b1, 1'b0, 1'b0};
    wait_req(1'b1, 1'b0);
    dma_ctrl <= '{1'b1, 1'b1, 1'b0};
    // One free byte but a whole word written: the rest is lost
    do_beat(1'b1, 32'h0);
    wait_req(1'b1, 1'b0);
    check(tx_count, COUNT_FULL);
    dma_ctrl <= '{1'b0, 1'b1, 1'b1};
    repeat (3) @(posedge core_clk);
    check(dma_req, 2'h0);
  endtask

  task automatic t_rx();
    dma_ctrl <= '{1'b1, 1'b0, 1'b1};
    repeat (3) @(posedge core_clk);
    check(dma_req, 2'h0);
    push_rx(8'ha5);
    wait_req(1'b0, 1'b1);
    do_beat(1'b0, 32'h0);
    check(rd, 32'h000000a5);
    wait_req(1'b0, 1'b0);
    dma_ctrl <= '{1'b0, 1'b0, 1'b1};
    for (int i = 1; i < 6; i++) push_rx(8'(i));
    @(posedge core_clk);
    check(rx_count, 10'h005);
    check(dma_req, 2'h0);
    do_beat(1'b0, 32'h0);
    check(rd, 32'h04030201);
    check(rx_count, COUNT_ONE);
    do_beat(1'b0, 32'h0);
    check(rd, 32'h00000005);
    check(rx_count, COUNT_ZERO);
    check(dma_req, 2'h0);
  endtask

  // Board reset in mid-run drops a live request and empties both queues
  task automatic t_reset();
    dma_ctrl <= '{1'b1, 1'b0, 1'b1};
    push_rx(8'h3c);
    wait_req(1'b0, 1'b1);
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    check(dma_req, 2'h0);
    check(rx_count, COUNT_ZERO);
    check(tx_count, COUNT_ZERO);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    check(dma_req, 2'h0);
    push_rx(8'h5a);
    wait_req(1'b0, 1'b1);
    do_beat(1'b0, 32'h0);
    check(rd, 32'h0000005a);
  endtask

  initial begin
    rst_n = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_byte = 8'h00;
    dma_ctrl = '0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    check(dma_req, 2'h0);
    check(tx_count, COUNT_ZERO);
    repeat (6) @(posedge core_clk);
    t_tx_order();
    t_tx_full();
    t_rx();
    t_reset();
    test_done();
  end
endmodule // testbench
`default_nettype wire

// *** rtl/byte_queue.sv ***
// Byte-wide FIFO with a live fill count.
// Assumes a push when full may be lost, as the queue drops it itself; reset is already synchronised.
`timescale 1ns/1ns
`default_nettype none
module byte_queue (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_sync_n,
  // Fill side
  input  wire logic                           push,
  input  wire logic [fifo_dma_pkg::BYTE_W-1:0] push_byte,
  // Drain side
  input  wire logic                           pop,
  output logic      [fifo_dma_pkg::BYTE_W-1:0] head,
  output logic      [fifo_dma_pkg::COUNT_W-1:0] count
);
  import fifo_dma_pkg::*;

  queue_state_type   st;
  queue_state_type   next_st;
  logic [BYTE_W-1:0] mem [QUEUE_DEPTH];
  logic              push_ok;
  logic              pop_ok;

  always_comb begin
    next_st = st;
    pop_ok  = pop && (st.count != COUNT_ZERO);
    // A push into a full queue is lost unless a byte leaves in the same cycle
    push_ok = push && ((st.count != COUNT_FULL) || pop_ok);
    if (push_ok) begin
      next_st.wr_ptr = st.wr_ptr + PTR_ONE;
    end
    if (pop_ok) begin
      next_st.rd_ptr = st.rd_ptr + PTR_ONE;
    end
    if (push_ok && !pop_ok) begin
      next_st.count = st.count + COUNT_ONE;
    end else if (pop_ok && !push_ok) begin
      next_st.count = st.count - COUNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st <= QUEUE_STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Storage carries no reset so it maps onto block RAM
  always_ff @(posedge clk) begin
    if (push_ok) begin
      mem[st.wr_ptr] <= push_byte;
    end
  end

  assign head  = mem[st.rd_ptr];
  assign count = st.count;

endmodule // byte_queue
`default_nettype wire

// *** rtl/fifo_dma_demand_handshake.sv ***
// One channel's FIFO data location and DMA demand handshake toward the bus bridge.
// Assumes bridge, serial logic and this block share core_clk; bridge waits for ack per beat.
//
// Behaviour
// - Two DMA modes, non-demand and demand; the bridge selects which.
// - Non-demand mode accepts or supplies every beat, no FIFO state check.
// - Demand transmit request drops while the transmit FIFO is full.
// - Demand receive request drops while the receive FIFO is empty.
// - Each beat moves four bytes; partial words are not protected.
// - Each FIFO keeps a live count of bytes it holds.
// - No record is kept of bytes moved by an unfinished demand transfer.
// - One data location: writes push transmit, reads pop receive.
`timescale 1ns/1ns
`default_nettype none
module fifo_dma_demand_handshake (
  // Clock and reset
  input  wire logic                              core_clk,
  input  wire logic                              rst_n,
  // Bridge data location
  input  wire fifo_dma_pkg::bus_req_type          bus_req,
  output fifo_dma_pkg::bus_resp_type              bus_resp,
  // Bridge DMA control and demand requests
  input  wire fifo_dma_pkg::dma_ctrl_type         dma_ctrl,
  output fifo_dma_pkg::dma_req_type               dma_req,
  // Serial transmit side
  input  wire logic                              tx_pop,
  output logic      [fifo_dma_pkg::BYTE_W-1:0]    tx_byte,
  output logic                                   tx_byte_valid,
  // Serial receive side
  input  wire logic                              rx_push,
  input  wire logic [fifo_dma_pkg::BYTE_W-1:0]    rx_byte,
  // Fill levels
  output logic      [fifo_dma_pkg::COUNT_W-1:0]   tx_count,
  output logic      [fifo_dma_pkg::COUNT_W-1:0]   rx_count
);
  import fifo_dma_pkg::*;

  logic [1:0]         rst_pipe;
  logic               rst_sync_n;
  hs_state_type       st;
  hs_state_type       next_st;
  logic               q_tx_push;
  logic               q_tx_pop;
  logic               q_rx_pop;
  logic [BYTE_W-1:0]  tx_head;
  logic [BYTE_W-1:0]  rx_head;
  logic [BYTE_W-1:0]  rd_byte;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'h1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  byte_queue u_transmit_queue (
    .clk        (core_clk),
    .rst_sync_n (rst_sync_n),
    .push       (q_tx_push),
    .push_byte  (st.wbuf[BYTE_W-1:0]),
    .pop        (q_tx_pop),
    .head       (tx_head),
    .count      (tx_count)
  );

  byte_queue u_receive_queue (
    .clk        (core_clk),
    .rst_sync_n (rst_sync_n),
    .push       (rx_push),
    .push_byte  (rx_byte),
    .pop        (q_rx_pop),
    .head       (rx_head),
    .count      (rx_count)
  );

  always_comb begin
    next_st               = st;
    next_st.bus_resp.ack  = 1'h0;
    next_st.tx_byte_valid = 1'h0;
    q_tx_push             = 1'h0;
    q_rx_pop              = 1'h0;
    q_tx_pop              = tx_pop && (tx_count != COUNT_ZERO);
    rd_byte               = (rx_count != COUNT_ZERO) ? rx_head : INVALID_BYTE;
    if (q_tx_pop) begin
      next_st.tx_byte       = tx_head;
      next_st.tx_byte_valid = 1'h1;
    end
    case (st.beat)
      BEAT_IDLE: begin
        // Same location serves both directions; a write wins a same-cycle collision
        // The ack cycle is a gap, so a master still holding its request is not taken twice
        if (st.bus_resp.ack) begin
          next_st.beat = BEAT_IDLE;
        end else if (bus_req.write) begin
          next_st.beat = BEAT_WRITE;
          next_st.wbuf = bus_req.wdata;
          next_st.idx  = FIRST_BYTE_IDX;
        end else if (bus_req.read) begin
          next_st.beat = BEAT_READ;
          next_st.idx  = FIRST_BYTE_IDX;
        end
      end
      BEAT_WRITE: begin
        // All four lanes go in, even if only the low byte was meant; a full queue drops them
        q_tx_push    = 1'h1;
        next_st.wbuf = {BYTE_ZERO, st.wbuf[BEAT_W-1:BYTE_W]};
        next_st.idx  = st.idx + BYTE_IDX_STEP;
        if (st.idx == LAST_BYTE_IDX) begin
          next_st.beat         = BEAT_IDLE;
          next_st.bus_resp.ack = 1'h1;
        end
      end
      BEAT_READ: begin
        // Byte 0 ends up in the low lane; an empty queue yields filler bytes
        q_rx_pop              = 1'h1;
        next_st.bus_resp.rdata = {rd_byte, st.bus_resp.rdata[BEAT_W-1:BYTE_W]};
        next_st.idx           = st.idx + BYTE_IDX_STEP;
        if (st.idx == LAST_BYTE_IDX) begin
          next_st.beat         = BEAT_IDLE;
          next_st.bus_resp.ack = 1'h1;
        end
      end
      default: begin
        next_st.beat = BEAT_IDLE;
      end
    endcase
    // Beats are not counted: only fill levels are visible, never bytes moved
    // Mode select gates both requests; non-demand transfers never see them
    next_st.dma_req.tx_req = dma_ctrl.demand_mode && dma_ctrl.tx_active
                             && (tx_count != COUNT_FULL);
    next_st.dma_req.rx_req = dma_ctrl.demand_mode && dma_ctrl.rx_active
                             && (rx_count != COUNT_ZERO);
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st <= HS_STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign bus_resp      = st.bus_resp;
  assign dma_req       = st.dma_req;
  assign tx_byte       = st.tx_byte;
  assign tx_byte_valid = st.tx_byte_valid;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_n);

  sequence write_taken;
    (st.beat == BEAT_IDLE) && !bus_resp.ack && bus_req.write;
  endsequence

  sequence read_taken;
    (st.beat == BEAT_IDLE) && !bus_resp.ack && !bus_req.write && bus_req.read;
  endsequence

  tx_req_gate_a: assert property (
    !(dma_ctrl.demand_mode && dma_ctrl.tx_active) |=> !dma_req.tx_req)
    else $error("transmit request outside demand transfer");

  rx_req_gate_a: assert property (
    !(dma_ctrl.demand_mode && dma_ctrl.rx_active) |=> !dma_req.rx_req)
    else $error("receive request outside demand transfer");

  tx_full_stall_a: assert property (
    (tx_count == COUNT_FULL) |=> !dma_req.tx_req)
    else $error("transmit request while queue full");

  // Sampled reset term keeps the release edge, where state is still cleared, out of it
  tx_space_req_a: assert property (
    (rst_sync_n && dma_ctrl.demand_mode && dma_ctrl.tx_active && tx_count != COUNT_FULL)
    |=> dma_req.tx_req)
    else $error("transmit request missing with space");

  rx_data_req_a: assert property (
    (dma_ctrl.demand_mode && dma_ctrl.rx_active) |=> dma_req.rx_req == $past(rx_count != COUNT_ZERO))
    else $error("receive request does not follow queue level");

  write_beat_ack_a: assert property (
    write_taken |=> (!bus_resp.ack)[*4] ##1 bus_resp.ack ##1 !bus_resp.ack)
    else $error("write beat not acknowledged after four bytes");

  read_beat_ack_a: assert property (
    read_taken |-> ##1 (st.beat == BEAT_READ)[*4] ##1 bus_resp.ack)
    else $error("read beat not acknowledged after four bytes");

  tx_count_up_a: assert property (
    (st.beat == BEAT_WRITE && tx_count != COUNT_FULL && !tx_pop)
    |=> tx_count == $past(tx_count) + COUNT_ONE)
    else $error("transmit count missed a pushed byte");

  rx_count_down_a: assert property (
    (st.beat == BEAT_READ && rx_count != COUNT_ZERO && !rx_push)
    |=> rx_count == $past(rx_count) - COUNT_ONE)
    else $error("receive count missed a popped byte");

  rx_push_count_a: assert property (
    (rx_push && rx_count != COUNT_FULL && st.beat != BEAT_READ)
    |=> rx_count == $past(rx_count) + COUNT_ONE)
    else $error("receive count missed a pushed byte");

  ack_gap_a: assert property (
    (bus_resp.ack && (bus_req.write || bus_req.read)) |=> (st.beat == BEAT_IDLE))
    else $error("request held through ack started a second beat");

  read_lane_data_a: assert property (
    (st.beat == BEAT_READ && rx_count != COUNT_ZERO)
    |=> bus_resp.rdata[BEAT_W-1:BEAT_W-BYTE_W] == $past(rx_head))
    else $error("read lane does not carry the popped byte");

  read_lane_fill_a: assert property (
    (st.beat == BEAT_READ && rx_count == COUNT_ZERO)
    |=> bus_resp.rdata[BEAT_W-1:BEAT_W-BYTE_W] == INVALID_BYTE)
    else $error("read lane past stored data is not the filler byte");

  tx_pop_byte_a: assert property (
    (tx_pop && tx_count != COUNT_ZERO) |=> tx_byte_valid && (tx_byte == $past(tx_head)))
    else $error("transmit byte not presented after a pop");

endmodule // fifo_dma_demand_handshake
`default_nettype wire

// *** rtl/fifo_dma_pkg.sv ***
// Constants, carrier structs and state types for the FIFO DMA handshake block.
// Assumes a single core clock shared by the bridge DMA side and the serial side.
package fifo_dma_pkg;

  localparam int              BYTE_W           = 8;
  localparam int              BEAT_W           = 32;
  localparam int              QUEUE_DEPTH      = 512;
  localparam int              PTR_W            = 9;
  localparam int              COUNT_W          = 10;
  localparam logic [COUNT_W-1:0] COUNT_FULL    = 10'h200;
  localparam logic [COUNT_W-1:0] COUNT_ZERO    = 10'h000;
  localparam logic [COUNT_W-1:0] COUNT_ONE     = 10'h001;
  localparam logic [PTR_W-1:0]   PTR_ONE       = 9'h001;
  localparam logic [1:0]      FIRST_BYTE_IDX   = 2'h0;
  localparam logic [1:0]      LAST_BYTE_IDX    = 2'h3;
  localparam logic [1:0]      BYTE_IDX_STEP    = 2'h1;
  localparam logic [BYTE_W-1:0] INVALID_BYTE   = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_ZERO      = 8'h00;

  typedef enum logic [1:0] {
    BEAT_IDLE,
    BEAT_WRITE,
    BEAT_READ
  } beat_type;

  // One 32-bit access to the channel data location
  typedef struct packed {
    logic              write;
    logic              read;
    logic [BEAT_W-1:0] wdata;
  } bus_req_type;

  typedef struct packed {
    logic              ack;
    logic [BEAT_W-1:0] rdata;
  } bus_resp_type;

  // Transfer setup chosen by the bridge
  typedef struct packed {
    logic demand_mode;
    logic tx_active;
    logic rx_active;
  } dma_ctrl_type;

  typedef struct packed {
    logic tx_req;
    logic rx_req;
  } dma_req_type;

  typedef struct packed {
    beat_type          beat;
    logic [1:0]        idx;
    logic [BEAT_W-1:0] wbuf;
    bus_resp_type      bus_resp;
    dma_req_type       dma_req;
    logic [BYTE_W-1:0] tx_byte;
    logic              tx_byte_valid;
  } hs_state_type;

  typedef struct packed {
    logic [PTR_W-1:0]   wr_ptr;
    logic [PTR_W-1:0]   rd_ptr;
    logic [COUNT_W-1:0] count;
  } queue_state_type;

  localparam hs_state_type    HS_STATE_RESET    = '0;
  localparam queue_state_type QUEUE_STATE_RESET = '0;

endpackage
